//--- src/tfc_pkg.sv
package tfc_pkg;
    // register addresses (8-bit special-register bus)
    localparam logic [7:0] TFC_ADDR_MODE_EXT = 8'h93;
    localparam logic [7:0] TFC_ADDR_MODE_MAIN = 8'hC9;
    localparam logic [7:0] TFC_ADDR_COUNT_LOW = 8'hCC;
    localparam logic [7:0] TFC_ADDR_CONTROL = 8'hC8;
    localparam logic [7:0] TFC_ADDR_COUNT_HIGH = 8'hCD;
    localparam logic [7:0] TFC_ADDR_CAPTURE_LOW = 8'hCA;
    localparam logic [7:0] TFC_ADDR_CAPTURE_HIGH = 8'hCB;
    // reset values
    localparam logic [7:0] TFC_RST_MODE_EXT = 8'h00;
    localparam logic [7:0] TFC_RST_MODE_MAIN = 8'h00;
    localparam logic [7:0] TFC_RST_COUNT_LOW = 8'h00;
    localparam logic [7:0] TFC_RST_CONTROL = 8'h00;
    // control register bits
    localparam int TFC_CON_OVF = 7;
    localparam int TFC_CON_EXT = 6;
    localparam int TFC_CON_LOVF = 5;
    localparam int TFC_CON_LIE = 4;
    localparam int TFC_CON_FALL = 3;
    localparam int TFC_CON_RUN = 2;
    localparam int TFC_CON_CSEL = 1;
    localparam int TFC_CON_CPRL = 0;
    // main mode register bits
    localparam int TFC_MOD_SPLIT = 7;
    localparam int TFC_MOD_B6 = 6;
    localparam int TFC_MOD_RISE = 5;
    localparam int TFC_MOD_X12 = 4;
    localparam int TFC_MOD_LRUN = 3;
    localparam int TFC_MOD_LRC = 2;
    localparam int TFC_MOD_OE = 1;
    localparam int TFC_MOD_MS0 = 0;
    // extension register bits
    localparam int TFC_EXT_LCS = 7;
    localparam int TFC_EXT_IGN = 6;
    localparam int TFC_EXT_ACC = 5;
    localparam int TFC_EXT_CKS = 4;
    localparam int TFC_EXT_MS1 = 3;
    localparam int TFC_EXT_CPS = 0;
    // clock prescale for the divide-by-twelve source
    localparam logic [3:0] TFC_DIV12_LAST = 4'hB;
    typedef enum logic [2:0]
    {
        TFC_MODE0 = 3'b000,
        TFC_MODE1 = 3'b001,
        TFC_MODE2 = 3'b010,
        TFC_MODE3 = 3'b011,
        TFC_MODE4 = 3'b100,
        TFC_MODE6 = 3'b110,
        TFC_MODE_RSV = 3'b111
    } tfc_mode_type;
endpackage

//--- src/tfc_sync.sv
`timescale 1ns/1ns
module tfc_sync #(
    parameter int WIDTH = 8
) (
    // clock and reset
    input wire logic clk,
    input wire logic rst,
    // level crossing
    input wire logic [WIDTH-1:0] asyncIn,
    output logic [WIDTH-1:0] syncOut
);
    logic [WIDTH-1:0] stage1_q;

    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            stage1_q <= '0;
            syncOut <= '0;
        end
        else
        begin
            stage1_q <= asyncIn;
            syncOut <= stage1_q;
        end
    end
endmodule

//--- src/tfc_tick_select.sv
`timescale 1ns/1ns
module tfc_tick_select (
    // clock and reset
    input wire logic clk,
    input wire logic rst,
    // candidate ticks
    input wire logic div12Tick,
    input wire logic pinRise,
    input wire logic [2:0] code,
    input wire logic evt3,
    input wire logic evt5,
    input wire logic evt6,
    input wire logic evt7,
    // selected tick, registered
    output logic tick
);
    logic sel;

    always_comb
    begin
        case (code)
            3'h0: sel = div12Tick;
            3'h1: sel = pinRise;
            3'h2: sel = 1'b1;
            3'h3: sel = evt3;
            3'h5: sel = evt5;
            3'h6: sel = evt6;
            3'h7: sel = evt7;
            default: sel = 1'b0;
        endcase
    end

    // registered so both halves see a clean one-cycle strobe
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
            tick <= 1'b0;
        else
            tick <= sel;
    end
endmodule

//--- src/tfc_timer.sv
`timescale 1ns/1ns
// Notes on behaviour
// - each 16-bit rollover sets the overflow flag and interrupt unless ignored.
// - split mode output toggles on low overflow; low byte reloads from capture.
// - low overflow feeds baud generator and clock output at once.
// - low overflow interrupt gated by low interrupt enable.
// - overflow flag set by hardware, cleared only by software write.
// - external flag set on enabled falling or rising trigger edge.
// - in power-down with interrupt enabled, external flag is a level wake.
// - low overflow flag set on split low-byte overflow.
// - low interrupt enable lets low overflow flag request interrupt.
// - falling-edge enable; mode 0 edges still set external flag.
// - run bit starts counter; in split mode only the high byte.
// - three-bit clock code selects among seven sources; code 4 selects none.
// - mode code decodes modes 0,1,2,3,6, and mode 4 in split mode only; others reserved.
// - split enable makes two 8-bit timers.
// - mode bit 6 is low x12 or input invert per access select.
// - input invert flips trigger input before edge detection.
// - low-run-clear clears low run on high overflow in modes 0/1 or on capture.
// - clock-out enable gates clock output onto its pin.
// - overflow interrupt ignore blocks overflow interrupt, reset zero.
// - capture source select picks one of seven trigger sources; codes 3 and 4 both tie it high.
// - clock-out mode when capture/reload zero and output enabled; 50% duty.
// - output rate is input clock over 2*(65536-capture); reload on overflow.
module tfc_timer (
    // clock and reset
    input wire logic clk,
    input wire logic rst,
    // register port
    input wire logic [7:0] regAddr,
    input wire logic regWrite,
    input wire logic [7:0] regWdata,
    input wire logic regRead,
    output logic [7:0] regRdata,
    // high byte and capture bytes kept outside
    input wire logic [7:0] countHighByte,
    input wire logic [7:0] captureHighByte,
    input wire logic [7:0] captureLowByte,
    output logic highOverflow,
    output logic highTick,
    output logic highRun,
    // pins and events
    input wire logic trigger_pin,
    input wire logic clockInPin,
    input wire logic slave_select_pin,
    input wire logic second_two_wire_clock,
    input wire logic comparator0_output,
    input wire logic comparator2_output,
    input wire logic ext_irq2_event,
    input wire logic ext_irq3_event,
    input wire logic timer0_overflow_event,
    input wire logic comparator0_event,
    input wire logic comparator2_event,
    input wire logic powerDown,
    input wire logic timerIrqEnable,
    // to mode datapaths and system
    output tfc_pkg::tfc_mode_type modeSelect,
    output logic splitMode,
    output logic triggerEvent,
    output logic captureEvent,
    output logic low_half_overflow_event,
    output logic clock_output_pin,
    output logic timerIrq,
    output logic wakeRequest
);
    import tfc_pkg::*;

    logic [7:0] control_q;
    logic [7:0] modeMain_q;
    logic [7:0] modeExt_q;
    logic [7:0] countLow_q;
    logic lowX12_q;
    logic invert_q;
    logic clockOut_q;
    logic trigPrev_q;
    logic pinPrev_q;
    logic [3:0] div12_q;
    logic div12Tick;
    logic [5:0] pinsSync;
    logic [2:0] arm_q;
    logic edgeArmed;
    logic trigSel;
    logic trigIn;
    logic trigRise;
    logic trigFall;
    logic pinRise;
    logic lowTick;
    logic lowOvf;
    logic ovfEvent;
    logic extSet;
    logic lowRunClr;
    logic [2:0] clkCode;
    logic wrCon;
    logic wrMain;
    logic wrExt;
    logic wrLow;

    function automatic logic hit(input logic [7:0] a, input logic [7:0] target, input logic w);
        hit = w && (a == target);
    endfunction

    function automatic logic reloadMode(input tfc_mode_type m);
        reloadMode = (m == TFC_MODE0) || (m == TFC_MODE1);
    endfunction

    function automatic logic captureMode(input tfc_mode_type m);
        captureMode = (m == TFC_MODE2) || (m == TFC_MODE3);
    endfunction

    assign wrCon = hit(regAddr, TFC_ADDR_CONTROL, regWrite);
    assign wrMain = hit(regAddr, TFC_ADDR_MODE_MAIN, regWrite);
    assign wrExt = hit(regAddr, TFC_ADDR_MODE_EXT, regWrite);
    assign wrLow = hit(regAddr, TFC_ADDR_COUNT_LOW, regWrite);

    // pin inputs cross in through two flops before use
    tfc_sync #(.WIDTH(6)) pinSync (
        .clk(clk),
        .rst(rst),
        .asyncIn({trigger_pin, clockInPin, slave_select_pin, second_two_wire_clock,
                  comparator0_output, comparator2_output}),
        .syncOut(pinsSync)
    );

    assign splitMode = modeMain_q[TFC_MOD_SPLIT];

    always_comb
    begin
        case ({modeExt_q[TFC_EXT_MS1], control_q[TFC_CON_CPRL], modeMain_q[TFC_MOD_MS0]})
            3'b000: modeSelect = TFC_MODE0;
            3'b001: modeSelect = TFC_MODE1;
            3'b010: modeSelect = TFC_MODE2;
            3'b011: modeSelect = TFC_MODE3;
            3'b100: modeSelect = splitMode ? TFC_MODE4 : TFC_MODE_RSV;
            3'b110: modeSelect = TFC_MODE6;
            default: modeSelect = TFC_MODE_RSV;
        endcase
    end

    // capture source select
    always_comb
    begin
        case (modeExt_q[TFC_EXT_CPS +: 3])
            3'h0: trigSel = pinsSync[5];
            3'h1: trigSel = pinsSync[3];
            3'h2: trigSel = ext_irq3_event;
            3'h3: trigSel = 1'b1;
            3'h4: trigSel = 1'b1;
            3'h5: trigSel = pinsSync[1];
            3'h6: trigSel = pinsSync[0];
            default: trigSel = pinsSync[2];
        endcase
    end

    // edges stay blind until the pin pipeline has filled after reset;
    // a pin idling high would otherwise look like a fresh rising edge
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
            arm_q <= 3'h0;
        else
            arm_q <= {arm_q[1:0], 1'b1};
    end
    assign edgeArmed = arm_q[2];

    assign trigIn = trigSel ^ invert_q;
    assign trigRise = edgeArmed && trigIn && !trigPrev_q;
    assign trigFall = edgeArmed && !trigIn && trigPrev_q;
    assign pinRise = edgeArmed && pinsSync[4] && !pinPrev_q;
    assign triggerEvent = (trigFall && control_q[TFC_CON_FALL]) || (trigRise && modeMain_q[TFC_MOD_RISE]);
    assign extSet = triggerEvent;
    assign captureEvent = triggerEvent && captureMode(modeSelect);

    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            trigPrev_q <= 1'b0;
            pinPrev_q <= 1'b0;
        end
        else
        begin
            trigPrev_q <= trigIn;
            pinPrev_q <= pinsSync[4];
        end
    end

    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
            div12_q <= 4'h0;
        else if (div12_q == TFC_DIV12_LAST)
            div12_q <= 4'h0;
        else
            div12_q <= div12_q + 4'h1;
    end
    assign div12Tick = (div12_q == TFC_DIV12_LAST);

    // split high byte takes the low overflow in place of the irq2 event
    assign clkCode = {modeExt_q[TFC_EXT_CKS], modeMain_q[TFC_MOD_X12], control_q[TFC_CON_CSEL]};
    tfc_tick_select highSel (
        .clk(clk),
        .rst(rst),
        .div12Tick(div12Tick),
        .pinRise(pinRise),
        .code(clkCode),
        .evt3(splitMode ? lowOvf : ext_irq2_event),
        .evt5(timer0_overflow_event),
        .evt6(comparator2_event),
        .evt7(comparator0_event),
        .tick(highTick)
    );

    assign highRun = control_q[TFC_CON_RUN];

    // low half clock: 00 div12, 01 system_clock, 11 irq2 event, 10 none
    always_comb
    begin
        case ({modeExt_q[TFC_EXT_LCS], lowX12_q})
            2'b00: lowTick = div12Tick;
            2'b01: lowTick = 1'b1;
            2'b11: lowTick = ext_irq2_event;
            default: lowTick = 1'b0;
        endcase
    end

    // unsplit: low byte runs with the run bit; split: low-run bit only
    logic lowCount;
    assign lowCount = splitMode ? (modeMain_q[TFC_MOD_LRUN] && lowTick) : (highRun && highTick);
    assign lowOvf = splitMode && lowCount && (countLow_q == 8'hFF);
    assign low_half_overflow_event = lowOvf;
    // 16-bit overflow comes when both bytes roll in one step;
    // split: the high byte alone rolls and still owns the overflow flag
    assign highOverflow = splitMode ? (highRun && highTick && countHighByte == 8'hFF) :
        (lowCount && countLow_q == 8'hFF && countHighByte == 8'hFF);
    assign ovfEvent = highOverflow;

    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
            countLow_q <= TFC_RST_COUNT_LOW;
        else if (wrLow)
            countLow_q <= regWdata;
        else if (lowOvf)
            countLow_q <= captureLowByte;
        // capture modes roll over freely; a reload would spoil the count
        else if (!splitMode && ovfEvent && reloadMode(modeSelect))
            countLow_q <= captureLowByte;
        else if (captureEvent && modeSelect == TFC_MODE3 && !splitMode)
            countLow_q <= 8'h00;
        else if (lowCount)
            countLow_q <= countLow_q + 8'h01;
    end

    assign lowRunClr = modeMain_q[TFC_MOD_LRC] && splitMode &&
        ((reloadMode(modeSelect) && highOverflow) ||
         (captureMode(modeSelect) && captureEvent));

    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            modeMain_q <= TFC_RST_MODE_MAIN;
            lowX12_q <= 1'b0;
            invert_q <= 1'b0;
        end
        else
        begin
            if (wrMain)
            begin
                modeMain_q <= regWdata;
                if (modeExt_q[TFC_EXT_ACC])
                    invert_q <= regWdata[TFC_MOD_B6];
                else
                    lowX12_q <= regWdata[TFC_MOD_B6];
            end
            if (lowRunClr)
                modeMain_q[TFC_MOD_LRUN] <= 1'b0;
        end
    end

    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
            modeExt_q <= TFC_RST_MODE_EXT;
        else if (wrExt)
            modeExt_q <= regWdata;
    end

    // flags: hardware set wins over a same-cycle software clear
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
            control_q <= TFC_RST_CONTROL;
        else
        begin
            if (wrCon)
                control_q <= regWdata;
            if (ovfEvent)
                control_q[TFC_CON_OVF] <= 1'b1;
            if (extSet)
                control_q[TFC_CON_EXT] <= 1'b1;
            if (lowOvf)
                control_q[TFC_CON_LOVF] <= 1'b1;
        end
    end

    // clock-out toggles on each low overflow in split mode, else on each 16-bit overflow, for 50% duty
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
            clockOut_q <= 1'b0;
        else if (control_q[TFC_CON_CPRL])
            clockOut_q <= 1'b0;
        else if (splitMode ? lowOvf : ovfEvent)
            clockOut_q <= ~clockOut_q;
    end
    assign clock_output_pin = clockOut_q && modeMain_q[TFC_MOD_OE];

    assign timerIrq = (control_q[TFC_CON_OVF] && !modeExt_q[TFC_EXT_IGN]) ||
        control_q[TFC_CON_EXT] ||
        (control_q[TFC_CON_LOVF] && control_q[TFC_CON_LIE]);
    // level wake; edge detection has no clock to rely on in power-down
    assign wakeRequest = powerDown && timerIrqEnable && control_q[TFC_CON_EXT];

    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
            regRdata <= 8'h00;
        else if (regRead)
        begin
            case (regAddr)
                TFC_ADDR_CONTROL: regRdata <= control_q;
                TFC_ADDR_MODE_MAIN: regRdata <= {modeMain_q[7], modeExt_q[TFC_EXT_ACC] ? invert_q : lowX12_q,
                                                 modeMain_q[5:0]};
                TFC_ADDR_MODE_EXT: regRdata <= modeExt_q;
                TFC_ADDR_COUNT_LOW: regRdata <= countLow_q;
                default: regRdata <= 8'h00;
            endcase
        end
    end
endmodule

//--- bench/tfc_timer_monitor.sv
`timescale 1ns/1ns
module tfc_timer_monitor
    import tfc_pkg::*;
(
    // clock and reset
    input wire logic clk,
    input wire logic rst,
    // register port
    input wire logic [7:0] regAddr,
    input wire logic regWrite,
    input wire logic [7:0] regWdata,
    input wire logic regRead,
    input wire logic [7:0] regRdata,
    // outputs and levels
    input wire logic highOverflow,
    input wire logic low_half_overflow_event,
    input wire logic clock_output_pin,
    input wire logic timerIrq,
    input wire logic wakeRequest,
    input wire logic powerDown,
    input wire logic timerIrqEnable,
    input wire logic splitMode,
    input tfc_pkg::tfc_mode_type modeSelect
);
    logic oe_q, cprl_q, lie_q, ign_q, ms0_q, ms1_q;
    logic [2:0] code;
    logic [2:0] expMode;
    assign code = {ms1_q, cprl_q, ms0_q};
    assign expMode = (code == 3'h5 || code == 3'h7) ? 3'h7 : code;
    // only bits that hardware never changes are shadowed
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
            {oe_q, cprl_q, lie_q, ign_q, ms0_q, ms1_q} <= 6'h00;
        else if (regWrite && regAddr == TFC_ADDR_CONTROL)
            {lie_q, cprl_q} <= {regWdata[4], regWdata[0]};
        else if (regWrite && regAddr == TFC_ADDR_MODE_MAIN)
            {oe_q, ms0_q} <= {regWdata[1], regWdata[0]};
        else if (regWrite && regAddr == TFC_ADDR_MODE_EXT)
            {ign_q, ms1_q} <= {regWdata[6], regWdata[3]};
    end
    default clocking mcb @(posedge clk);
    endclocking
    default disable iff (rst);
    sequence outQuiet;
        (!oe_q || cprl_q) [*2];
    endsequence
    sequence outSteady;
        (oe_q && !cprl_q && !low_half_overflow_event && !highOverflow) ##1 (oe_q && !cprl_q);
    endsequence
    split_follows_a: assert property (regWrite && regAddr == TFC_ADDR_MODE_MAIN |=> splitMode == $past(regWdata[7]))
        else $error("split mode differs from written bit");
    mode_decode_a: assert property (splitMode || code != 3'h4 |-> modeSelect == expMode)
        else $error("mode decode wrong");
    low_toggle_a: assert property (low_half_overflow_event && splitMode && oe_q && !cprl_q |=> $changed(clock_output_pin))
        else $error("clock pin missed a low overflow");
    high_toggle_a: assert property (highOverflow && !splitMode && oe_q && !cprl_q |=> $changed(clock_output_pin))
        else $error("clock pin missed an overflow");
    out_quiet_a: assert property (outQuiet |-> !clock_output_pin)
        else $error("clock pin driven while disabled");
    out_steady_a: assert property (outSteady |-> $stable(clock_output_pin))
        else $error("clock pin moved without overflow");
    ovf_irq_a: assert property (highOverflow ##1 !ign_q |-> timerIrq)
        else $error("overflow raised no interrupt");
    low_irq_a: assert property (low_half_overflow_event ##1 lie_q |-> timerIrq)
        else $error("low overflow raised no interrupt");
    wake_gate_a: assert property (wakeRequest |-> powerDown && timerIrqEnable)
        else $error("wake outside power-down");
endmodule
bind tfc_timer tfc_timer_monitor mon (.clk, .rst, .regAddr, .regWrite, .regWdata, .regRead, .regRdata,
    .highOverflow, .low_half_overflow_event, .clock_output_pin, .timerIrq, .wakeRequest, .powerDown,
    .timerIrqEnable, .splitMode, .modeSelect);

//--- bench/tfc_pin_model.sv
`timescale 1ns/1ns
module tfc_pin_model (
    // clock
    input wire logic clk,
    // pins toward the timer
    output logic trigger_pin,
    output logic clockInPin,
    output logic slave_select_pin,
    output logic second_two_wire_clock,
    output logic comparator0_output,
    output logic comparator2_output
);
    // select and two-wire clock sit at their pull-up level
    initial
    begin
        {trigger_pin, clockInPin, slave_select_pin} = 3'h5;
        {second_two_wire_clock, comparator0_output, comparator2_output} = 3'h4;
    end
    task automatic setTrigger(input logic v);
        @(negedge clk);
        trigger_pin = v;
    endtask
endmodule

//--- bench/timer_four_clockout_and_modes_test.sv
`timescale 1ns/1ns
module timer_four_clockout_and_modes_test;
    import tfc_pkg::*;
    localparam logic [7:0] CON = TFC_ADDR_CONTROL;
    localparam logic [7:0] MAIN = TFC_ADDR_MODE_MAIN;
    localparam logic [7:0] EXT = TFC_ADDR_MODE_EXT;
    localparam logic [7:0] LOW = TFC_ADDR_COUNT_LOW;
    logic clk, rst, regWrite, regRead, powerDown, timerIrqEnable;
    logic [7:0] regAddr, regWdata, regRdata, capLow, hiByte;
    logic [4:0] evts;
    logic highOverflow, low_half_overflow_event, clock_output_pin, timerIrq, wakeRequest, splitMode;
    logic trigEvt, capEvt, runLvl, hiTick;
    logic trigger_pin, clockInPin, slave_select_pin, second_two_wire_clock, comparator0_output, comparator2_output;
    tfc_mode_type modeSelect;
    int errorCnt, testsRun, n;
    tfc_pin_model pins (.clk, .trigger_pin, .clockInPin, .slave_select_pin, .second_two_wire_clock,
        .comparator0_output, .comparator2_output);
    tfc_timer DUT (.clk, .rst, .regAddr, .regWrite, .regWdata, .regRead, .regRdata, .countHighByte(hiByte),
        .captureHighByte(hiByte), .captureLowByte(capLow), .highOverflow, .highTick(hiTick), .highRun(runLvl),
        .trigger_pin,
        .clockInPin, .slave_select_pin, .second_two_wire_clock, .comparator0_output, .comparator2_output,
        .ext_irq2_event(evts[0]), .ext_irq3_event(evts[1]), .timer0_overflow_event(evts[2]),
        .comparator0_event(evts[3]), .comparator2_event(evts[4]), .powerDown, .timerIrqEnable, .modeSelect,
        .splitMode, .triggerEvent(trigEvt), .captureEvent(capEvt), .low_half_overflow_event, .clock_output_pin,
        .timerIrq,
        .wakeRequest);
    task automatic check(input logic [7:0] got, input logic [7:0] exp);
        testsRun++;
        if (got !== exp)
        begin
            errorCnt++;
            $display("unexpected at %0t: got %0h expected %0h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge clk);
        {regAddr, regWdata, regWrite} = {a, d, 1'b1};
        @(negedge clk);
        regWrite = 1'b0;
    endtask
    task automatic rdChk(input logic [7:0] a, input logic [7:0] exp);
        @(negedge clk);
        {regAddr, regRead} = {a, 1'b1};
        @(negedge clk);
        regRead = 1'b0;
        check(regRdata, exp);
    endtask
    function automatic logic hit(input int sel, input logic last);
        return sel == 0 ? low_half_overflow_event === 1'b1 : sel == 1 ? highOverflow === 1'b1 : clock_output_pin !== last;
    endfunction
    // first pass aligns to an event, second counts cycles to the next
    task automatic gap(input int sel, output int cnt);
        logic last;
        last = clock_output_pin;
        repeat (2)
        begin
            cnt = 0;
            do
            begin
                @(negedge clk);
                cnt++;
            end while (!hit(sel, last) && cnt < 50);
            last = clock_output_pin;
        end
    endtask
    task automatic testRegs;
        rdChk(CON, TFC_RST_CONTROL);
        rdChk(MAIN, TFC_RST_MODE_MAIN);
        rdChk(EXT, TFC_RST_MODE_EXT);
        rdChk(LOW, TFC_RST_COUNT_LOW);
        wr(8'h00, 8'hFF);
        rdChk(8'h00, 8'h00);
        wr(LOW, 8'h5A);
        rdChk(LOW, 8'h5A);
        wr(EXT, 8'h5A);
        rdChk(EXT, 8'h5A);
        wr(EXT, 8'h00);
        $display("register test done");
    endtask
    task automatic testModes;
        logic [2:0] exp;
        for (int i = 0; i < 8; i++)
        begin
            wr(EXT, {4'h0, i[2], 3'h0});
            wr(CON, {7'h00, i[1]});
            wr(MAIN, {7'h40, i[0]});
            exp = (i == 5 || i == 7) ? 3'h7 : i[2:0];
            check({5'h00, modeSelect}, {5'h00, exp});
        end
        wr(CON, 8'h00);
        wr(MAIN, 8'h00);
        check({5'h00, modeSelect}, {5'h00, TFC_MODE_RSV});
        wr(EXT, 8'h00);
        $display("mode test done");
    endtask
    task automatic testSplit;
        capLow = 8'hFD;
        wr(MAIN, 8'hC0);
        wr(LOW, 8'hFD);
        wr(MAIN, 8'hC2);
        wr(MAIN, 8'hCA);
        gap(0, n);
        check(n[7:0], 8'h03);
        gap(2, n);
        check(n[7:0], 8'h03);
        rdChk(CON, 8'h20);
        check({7'h00, timerIrq}, 8'h00);
        wr(CON, 8'h10);
        gap(0, n);
        @(negedge clk);
        check({7'h00, timerIrq}, 8'h01);
        wr(MAIN, 8'hC2);
        wr(CON, 8'h00);
        rdChk(CON, 8'h00);
        wr(MAIN, 8'h00);
        $display("split clock-out test done");
    endtask
    task automatic test16;
        {capLow, hiByte} = 16'hFEFF;
        wr(MAIN, 8'h10);
        wr(LOW, 8'hFE);
        wr(MAIN, 8'h12);
        wr(CON, 8'h04);
        gap(1, n);
        check(n[7:0], 8'h02);
        gap(2, n);
        check(n[7:0], 8'h02);
        rdChk(CON, 8'h84);
        check({7'h00, timerIrq}, 8'h01);
        wr(EXT, 8'h40);
        check({7'h00, timerIrq}, 8'h00);
        wr(CON, 8'h80);
        wr(CON, 8'h00);
        rdChk(CON, 8'h00);
        wr(EXT, 8'h00);
        wr(MAIN, 8'h00);
        $display("clock-out test done");
    endtask
    task automatic testExt;
        wr(CON, 8'h08);
        pins.setTrigger(1'b0);
        repeat (6) @(negedge clk);
        rdChk(CON, 8'h48);
        {timerIrqEnable, powerDown} = 2'h1;
        @(negedge clk);
        check({7'h00, wakeRequest}, 8'h00);
        timerIrqEnable = 1'b1;
        @(negedge clk);
        check({7'h00, wakeRequest}, 8'h01);
        powerDown = 1'b0;
        wr(CON, 8'h08);
        wr(EXT, 8'h20);
        wr(MAIN, 8'h40);
        repeat (6) @(negedge clk);
        rdChk(CON, 8'h08);
        pins.setTrigger(1'b1);
        repeat (6) @(negedge clk);
        rdChk(CON, 8'h48);
        wr(CON, 8'h00);
        wr(MAIN, 8'h00);
        wr(EXT, 8'h00);
        wr(CON, 8'h09);
        n = 0;
        pins.setTrigger(1'b0);
        repeat (6)
        begin
            @(negedge clk);
            n += (capEvt === 1'b1 && trigEvt === 1'b1) ? 1 : 0;
        end
        check(n[7:0], 8'h01);
        rdChk(CON, 8'h49);
        wr(CON, 8'h00);
        $display("external flag test done");
    endtask
    task automatic testLowClear;
        hiByte = 8'hFF;
        wr(LOW, 8'h10);
        wr(MAIN, 8'h94);
        wr(CON, 8'h04);
        check({7'h00, runLvl}, 8'h01);
        check({7'h00, hiTick}, 8'h01);
        rdChk(LOW, 8'h10);
        wr(CON, 8'h00);
        wr(MAIN, 8'h9C);
        rdChk(MAIN, 8'h9C);
        wr(CON, 8'h04);
        rdChk(MAIN, 8'h94);
        wr(CON, 8'h00);
        wr(MAIN, 8'h00);
        $display("low run clear test done");
    endtask
    task automatic wrapUp;
        $display("comparisons %0d mismatches %0d", testsRun, errorCnt);
        if (errorCnt == 0 && testsRun > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask
    initial
    begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end
    // the whole run needs a few hundred cycles; allow about 2000
    initial
    begin
        #100000;
        errorCnt++;
        wrapUp();
    end
    initial
    begin
        {rst, timerIrqEnable, regWrite, regRead, powerDown} = 5'h18;
        {regAddr, regWdata, capLow, hiByte} = 32'h0;
        evts = 5'h00;
        errorCnt = 0;
        testsRun = 0;
        repeat (8) @(negedge clk);
        rst = 1'b0;
        testRegs();
        testModes();
        testSplit();
        test16();
        testExt();
        testLowClear();
        wrapUp();
    end
endmodule
